//--- csac_map.vh
// Register map, field positions, reset values and timing constants of the
// capacitive-sense auto-scan comparator. Included by the converter, the top and the bench.
// Operation
// - Start source code 111b enables auto-scan.
// - Scan start write also loads channel select in auto-scan.
// - Writing one to busy starts scanning.
// - After accumulation, advance to next analog pin.
// - Keep stepping until channel equals end.
// - Other analog pins with latch zero grounded.
// - After final channel, reload start channel.
// - Convert selected channel even if not analog.
// - Debug halt still finishes current rotation.
// - Suspend leaves scanning enabled and running.
// - Flag cleared if result <= threshold, else set.
// - Compare only after last accumulated conversion.
// - Set flag with enable raises interrupt.
// - Flag set stops scan until busy rewritten.
// - Greater-than event wakes from suspend always.
// - Length codes give 12, 13, 14 clocks.
`ifndef CSAC_MAP_VH
`define CSAC_MAP_VH

`define CSAC_OFS_CONTROL 8'h00
`define CSAC_OFS_CONFIG 8'h04
`define CSAC_OFS_SCAN_START 8'h08
`define CSAC_OFS_SCAN_END 8'h0C
`define CSAC_OFS_CHAN_SEL 8'h10
`define CSAC_OFS_THRESH_HIGH 8'h14
`define CSAC_OFS_THRESH_LOW 8'h18
`define CSAC_OFS_RESULT 8'h1C
`define CSAC_OFS_TIMING 8'h20
`define CSAC_OFS_IRQ_STATUS 8'h24
`define CSAC_OFS_IRQ_MASK 8'h28

`define CSAC_CTRL_GT_BIT 0
`define CSAC_CTRL_BUSY_BIT 1
`define CSAC_CFG_SRC_MSB 6
`define CSAC_CFG_SRC_LSB 4
`define CSAC_CFG_ACC_MSB 2
`define CSAC_CFG_ACC_LSB 0
`define CSAC_SRC_AUTOSCAN 3'h7
`define CSAC_ACC_MAX_SHIFT 3'h6
`define CSAC_TIM_LEN_MSB 7
`define CSAC_TIM_LEN_LSB 6
`define CSAC_TIM_DT_MSB 5
`define CSAC_TIM_DT_LSB 3
`define CSAC_TIM_IA_MSB 2
`define CSAC_TIM_IA_LSB 0

`define CSAC_IRQ_GT_BIT 0
`define CSAC_IRQ_DONE_BIT 1
`define CSAC_IRQ_ROT_BIT 2

`define CSAC_RST_CONFIG 8'h00
`define CSAC_RST_TIMING 8'h40
`define CSAC_RST_CHAN 6'h00
`define CSAC_RST_THRESH 8'h00
`define CSAC_RST_IRQ 3'h0

`define CSAC_CONV_BASE_CLKS 4'hC
`define CSAC_CONV_MAX_CLKS 4'hE
`define CSAC_CLK_MHZ 100
`define CSAC_DT0_NS 750
`define CSAC_DT1_NS 1000
`define CSAC_DT2_NS 1200
`define CSAC_DT3_NS 1500
`define CSAC_DT4_NS 2000
`define CSAC_DT5_NS 3000
`define CSAC_DT6_NS 6000
`define CSAC_DT7_NS 12000

`endif

//--- csac_sync.v
// Three-stage synchroniser for an input from outside the clock domain.
// Assumes a free-running hclk; output follows once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module csac_sync (
  input wire hclk,
  input wire hresetn,
  input wire async_in,
  output reg sync_out
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end
endmodule // csac_sync
`default_nettype wire

//--- csac_conv.v
// One capacitive conversion: discharge phase, then a window of sense clocks
// in which rising edges of the front-end comparator pulse are counted.
// Assumes the analog front end drives sense_pulse and obeys discharge.
`timescale 1ns/1ns
`default_nettype none
`include "csac_map.vh"
module csac_conv #(
  parameter SENSE_DIV = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire [1:0] conv_len,
  input wire [2:0] dt_code,
  input wire sense_pulse,
  output reg discharge,
  output reg converting,
  output reg done,
  output reg [13:0] result
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DISCH = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [2:0] state;
  reg [10:0] dcnt;
  reg [3:0] scnt;
  reg [7:0] div;
  reg [13:0] edges;
  reg pulse_q;
  wire pulse_s;
  wire sense_en;
  wire [3:0] len_clks;

  function [10:0] dt_cycles;
    input [2:0] code;
    integer ns;
    integer cyc;
    begin
      case (code)
        3'h0: ns = `CSAC_DT0_NS;
        3'h1: ns = `CSAC_DT1_NS;
        3'h2: ns = `CSAC_DT2_NS;
        3'h3: ns = `CSAC_DT3_NS;
        3'h4: ns = `CSAC_DT4_NS;
        3'h5: ns = `CSAC_DT5_NS;
        3'h6: ns = `CSAC_DT6_NS;
        default: ns = `CSAC_DT7_NS;
      endcase
      cyc = (ns * `CSAC_CLK_MHZ + 999) / 1000;
      dt_cycles = cyc[10:0];
    end
  endfunction

  // Code 11 is reserved and runs as the longest conversion.
  assign len_clks = (conv_len == 2'h3) ? `CSAC_CONV_MAX_CLKS :
                    `CSAC_CONV_BASE_CLKS + {2'h0, conv_len};
  assign sense_en = (div == SENSE_DIV - 1);

  csac_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(sense_pulse),
    .sync_out(pulse_s)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      dcnt <= 11'h000;
      scnt <= 4'h0;
      div <= 8'h00;
      edges <= 14'h0000;
      pulse_q <= 1'b0;
      discharge <= 1'b0;
      converting <= 1'b0;
      done <= 1'b0;
      result <= 14'h0000;
    end else begin
      done <= 1'b0;
      pulse_q <= pulse_s;
      div <= sense_en ? 8'h00 : div + 8'h01;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_DISCH;
            dcnt <= dt_cycles(dt_code);
            discharge <= 1'b1;
            converting <= 1'b1;
          end
        end
        ST_DISCH: begin
          if (dcnt == 11'h001) begin
            state <= ST_CONV;
            discharge <= 1'b0;
            scnt <= 4'h0;
            edges <= 14'h0000;
          end
          dcnt <= dcnt - 11'h001;
        end
        ST_CONV: begin
          if (pulse_s & ~pulse_q) begin
            edges <= edges + 14'h0001;
          end
          if (sense_en) begin
            if (scnt == len_clks - 4'h1) begin
              state <= ST_IDLE;
              converting <= 1'b0;
              done <= 1'b1;
              result <= edges & ~(14'h3FFF << len_clks);
            end
            scnt <= scnt + 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          discharge <= 1'b0;
          converting <= 1'b0;
        end
      endcase
    end
  end
endmodule // csac_conv
`default_nettype wire

//--- csac_top.v
// Capacitive-sense auto-scan controller with threshold comparator.
// Assumes an AHB-Lite master on hclk and port analog/latch configuration
// provided as levels on the same clock; the analog front end is outside.
`timescale 1ns/1ns
`default_nettype none
`include "csac_map.vh"
module csac_top #(
  parameter NCH = 38,
  parameter SENSE_DIV = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [NCH-1:0] pin_analog,
  input wire [NCH-1:0] port_latch,
  input wire debug_halt,
  input wire suspend,
  input wire sense_pulse,
  output wire [5:0] channel_select,
  output wire discharge,
  output wire [2:0] charge_current,
  output reg [NCH-1:0] pin_ground_out,
  output reg [NCH-1:0] pin_ground_oe_n,
  output wire irq,
  output reg wake_req
);
  localparam SC_IDLE = 2'b01;
  localparam SC_RUN = 2'b10;

  reg [7:0] sense_config;
  reg [7:0] capsense_timing_config;
  reg [5:0] scan_start_channel;
  reg [5:0] scan_end_channel;
  reg [5:0] chan_sel;
  reg [7:0] threshold_high;
  reg [7:0] threshold_low;
  reg [15:0] result;
  reg greater_than_flag;
  reg sense_busy_bit;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  reg [1:0] scan_state;
  reg [6:0] acc_cnt;
  reg [20:0] acc_sum;
  reg conv_start;
  reg dp_wr;
  reg [7:0] dp_addr;
  reg [2:0] next_status;
  wire acc_take;
  wire wr_ctrl;
  wire busy_write;
  wire autoscan;
  wire [2:0] acc_shift;
  wire [20:0] sum_now;
  wire [20:0] sum_shift;
  wire [15:0] group_res;
  wire group_gt;
  wire group_end;
  wire conv_done;
  wire conv_active;
  wire [13:0] conv_res;
  integer i;

  // Next analog-configured channel above cur, not past last; else last.
  function [5:0] next_chan;
    input [5:0] cur;
    input [5:0] last;
    input [NCH-1:0] analog;
    integer k;
    begin
      next_chan = last;
      for (k = NCH - 1; k >= 0; k = k - 1) begin
        if (k > cur && k <= last && analog[k]) begin
          next_chan = k[5:0];
        end
      end
    end
  endfunction

  function [31:0] read_mux;
    input [7:0] ofs;
    begin
      case (ofs)
        `CSAC_OFS_CONTROL: read_mux = {30'h0, sense_busy_bit, greater_than_flag};
        `CSAC_OFS_CONFIG: read_mux = {24'h0, sense_config};
        `CSAC_OFS_SCAN_START: read_mux = {26'h0, scan_start_channel};
        `CSAC_OFS_SCAN_END: read_mux = {26'h0, scan_end_channel};
        `CSAC_OFS_CHAN_SEL: read_mux = {26'h0, chan_sel};
        `CSAC_OFS_THRESH_HIGH: read_mux = {24'h0, threshold_high};
        `CSAC_OFS_THRESH_LOW: read_mux = {24'h0, threshold_low};
        `CSAC_OFS_RESULT: read_mux = {16'h0, result};
        `CSAC_OFS_TIMING: read_mux = {24'h0, capsense_timing_config};
        `CSAC_OFS_IRQ_STATUS: read_mux = {29'h0, irq_status};
        `CSAC_OFS_IRQ_MASK: read_mux = {29'h0, irq_mask};
        default: read_mux = 32'h0;
      endcase
    end
  endfunction

  csac_conv #(
    .SENSE_DIV(SENSE_DIV)
  ) u_conv (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(conv_start),
    .conv_len(capsense_timing_config[`CSAC_TIM_LEN_MSB:`CSAC_TIM_LEN_LSB]),
    .dt_code(capsense_timing_config[`CSAC_TIM_DT_MSB:`CSAC_TIM_DT_LSB]),
    .sense_pulse(sense_pulse),
    .discharge(discharge),
    .converting(conv_active),
    .done(conv_done),
    .result(conv_res)
  );

  // The slave never stalls and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc_take = hsel & htrans[1] & hready;
  assign wr_ctrl = dp_wr & (dp_addr == `CSAC_OFS_CONTROL);
  assign busy_write = wr_ctrl & hwdata[`CSAC_CTRL_BUSY_BIT];

  assign autoscan = sense_config[`CSAC_CFG_SRC_MSB:`CSAC_CFG_SRC_LSB] ==
                    `CSAC_SRC_AUTOSCAN;
  assign acc_shift =
    (sense_config[`CSAC_CFG_ACC_MSB:`CSAC_CFG_ACC_LSB] > `CSAC_ACC_MAX_SHIFT) ?
    `CSAC_ACC_MAX_SHIFT : sense_config[`CSAC_CFG_ACC_MSB:`CSAC_CFG_ACC_LSB];
  assign sum_now = acc_sum + {7'h00, conv_res};
  assign group_end = conv_done & (acc_cnt == (7'h01 << acc_shift) - 7'h01);
  // Shift the whole sum first so that no high bits are lost before division.
  assign sum_shift = sum_now >> acc_shift;
  assign group_res = sum_shift[15:0];
  assign group_gt = group_res > {threshold_high, threshold_low};
  assign channel_select = chan_sel;
  assign charge_current =
    capsense_timing_config[`CSAC_TIM_IA_MSB:`CSAC_TIM_IA_LSB];
  assign irq = |(irq_status & irq_mask);

  // Grounds every other analog pin whose latch is low while converting.
  always @* begin
    for (i = 0; i < NCH; i = i + 1) begin
      pin_ground_out[i] = 1'b0;
      pin_ground_oe_n[i] = ~(conv_active && (i != chan_sel) &&
                             pin_analog[i] && !port_latch[i]);
    end
  end

  always @* begin
    next_status = irq_status;
    if (dp_wr && dp_addr == `CSAC_OFS_IRQ_STATUS) begin
      next_status = irq_status & ~hwdata[2:0];
    end
    if (group_end && group_gt) begin
      next_status[`CSAC_IRQ_GT_BIT] = 1'b1;
    end
    if (group_end) begin
      next_status[`CSAC_IRQ_DONE_BIT] = 1'b1;
    end
    if (group_end && !group_gt && autoscan && chan_sel == scan_end_channel) begin
      next_status[`CSAC_IRQ_ROT_BIT] = 1'b1;
    end
  end

  // Bus address phase is registered; read data is fetched at that edge.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      dp_wr <= acc_take & hwrite;
      if (acc_take) begin
        dp_addr <= haddr[7:0];
      end
      if (acc_take && !hwrite) begin
        hrdata <= read_mux(haddr[7:0]);
      end
    end
  end

  // Software-written configuration, and the interrupt status register.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_config <= `CSAC_RST_CONFIG;
      capsense_timing_config <= `CSAC_RST_TIMING;
      scan_start_channel <= `CSAC_RST_CHAN;
      scan_end_channel <= `CSAC_RST_CHAN;
      threshold_high <= `CSAC_RST_THRESH;
      threshold_low <= `CSAC_RST_THRESH;
      irq_mask <= `CSAC_RST_IRQ;
      irq_status <= `CSAC_RST_IRQ;
    end else begin
      irq_status <= next_status;
      if (dp_wr) begin
        case (dp_addr)
          `CSAC_OFS_CONFIG: sense_config <= {1'b0, hwdata[6:0]};
          `CSAC_OFS_SCAN_START: scan_start_channel <= hwdata[5:0];
          `CSAC_OFS_SCAN_END: scan_end_channel <= hwdata[5:0];
          `CSAC_OFS_THRESH_HIGH: threshold_high <= hwdata[7:0];
          `CSAC_OFS_THRESH_LOW: threshold_low <= hwdata[7:0];
          `CSAC_OFS_TIMING: capsense_timing_config <= hwdata[7:0];
          `CSAC_OFS_IRQ_MASK: irq_mask <= hwdata[2:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Scan sequencer; suspend only gates wake_req and never stops the scan.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_state <= SC_IDLE;
      sense_busy_bit <= 1'b0;
      greater_than_flag <= 1'b0;
      chan_sel <= `CSAC_RST_CHAN;
      result <= 16'h0000;
      acc_cnt <= 7'h00;
      acc_sum <= 21'h000000;
      conv_start <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      wake_req <= 1'b0;
      if (wr_ctrl && !hwdata[`CSAC_CTRL_GT_BIT]) begin
        greater_than_flag <= 1'b0;
      end
      if (dp_wr && dp_addr == `CSAC_OFS_CHAN_SEL) begin
        chan_sel <= hwdata[5:0];
      end
      if (dp_wr && dp_addr == `CSAC_OFS_SCAN_START && autoscan) begin
        chan_sel <= hwdata[5:0];
      end
      case (scan_state)
        SC_IDLE: begin
          if (busy_write) begin
            // Starts on whatever channel is selected now.
            scan_state <= SC_RUN;
            sense_busy_bit <= 1'b1;
            conv_start <= 1'b1;
            acc_cnt <= 7'h00;
            acc_sum <= 21'h000000;
          end
        end
        SC_RUN: begin
          if (conv_done && !group_end) begin
            acc_cnt <= acc_cnt + 7'h01;
            acc_sum <= sum_now;
            conv_start <= 1'b1;
          end
          if (group_end) begin
            acc_cnt <= 7'h00;
            acc_sum <= 21'h000000;
            result <= group_res;
            greater_than_flag <= group_gt;
            wake_req <= group_gt & suspend;
            if (group_gt || !autoscan) begin
              scan_state <= SC_IDLE;
              sense_busy_bit <= 1'b0;
            end else if (chan_sel == scan_end_channel) begin
              chan_sel <= scan_start_channel;
              if (debug_halt) begin
                scan_state <= SC_IDLE;
                sense_busy_bit <= 1'b0;
              end else begin
                conv_start <= 1'b1;
              end
            end else begin
              chan_sel <= next_chan(chan_sel, scan_end_channel,
                                    pin_analog);
              conv_start <= 1'b1;
            end
          end
        end
        default: begin
          scan_state <= SC_IDLE;
          sense_busy_bit <= 1'b0;
        end
      endcase
    end
  end
endmodule // csac_top
`default_nettype wire

//--- csac_properties.sv
// Port checks for the auto-scan comparator top.
// Assumes binding into csac_top with one clock and active-low reset.
`timescale 1ns/1ns
`default_nettype none
module csac_props #(
  parameter NCH = 38
) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire [NCH-1:0] pin_analog,
  input wire [NCH-1:0] port_latch,
  input wire suspend,
  input wire [5:0] channel_select,
  input wire discharge,
  input wire [NCH-1:0] pin_ground_out,
  input wire [NCH-1:0] pin_ground_oe_n,
  input wire irq,
  input wire wake_req
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire [NCH-1:0] gnd_on = ~pin_ground_oe_n;
  logic [10:0] dlen;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      dlen <= 11'h000;
    else
      dlen <= discharge ? dlen + 11'h001 : 11'h000;
  end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  chk_gnd_low: assert property (gnd_on != 0 |-> pin_ground_out == 0)
    else $error("grounded pin not driven low");
  chk_gnd_legal: assert property (
    (gnd_on & ~(pin_analog & ~port_latch)) == 0)
    else $error("pin grounded that is not analog with latch low");
  chk_sel_free: assert property (
    channel_select < NCH |-> pin_ground_oe_n[channel_select])
    else $error("selected channel grounded");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  chk_wake_susp: assert property (
    wake_req |-> suspend || $past(suspend))
    else $error("wake request outside suspend");
  chk_dis_len: assert property (
    $fell(discharge) |-> dlen >= 75 && dlen <= 1200)
    else $error("discharge length out of range");
  chk_chan_hold: assert property (
    discharge && $past(discharge) |-> $stable(channel_select))
    else $error("channel moved during discharge");
  chk_irq_after: assert property ($rose(irq) |-> !discharge)
    else $error("interrupt raised inside a conversion");
  cov_irq: cover property ($rose(irq));
  cov_wake: cover property (wake_req);
  cov_step: cover property ($changed(channel_select));
endmodule // csac_props
bind csac_top csac_props #(.NCH(NCH)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .pin_analog(pin_analog), .port_latch(port_latch),
  .suspend(suspend), .channel_select(channel_select),
  .discharge(discharge), .pin_ground_out(pin_ground_out),
  .pin_ground_oe_n(pin_ground_oe_n), .irq(irq), .wake_req(wake_req));
`default_nettype wire

//--- csac_electrode.sv
// Electrode and front-end stand-in: a touched pad toggles the pulse line.
// Assumes the scanner's channel_select and discharge as seen at the pins.
`timescale 1ns/1ns
`default_nettype none
module csac_electrode #(
  parameter NCH = 38
) (
  input wire hclk,
  input wire discharge,
  input wire [5:0] channel_select,
  input wire [NCH-1:0] touched,
  output logic sense_pulse
);
  logic [1:0] ph;
  initial sense_pulse = 1'b0;
  initial ph = 2'h0;
  // An untouched pad gives no edges, so its result is zero exactly.
  // A touched pad pulses with a period of four clocks, slow enough to
  // pass the three-stage input filter of the scanner.
  always @(posedge hclk) begin
    if (!discharge && channel_select < NCH && touched[channel_select]) begin
      ph <= ph + 2'h1;
      sense_pulse <= ph[1];
    end else begin
      ph <= 2'h0;
      sense_pulse <= 1'b0;
    end
  end
endmodule // csac_electrode
`default_nettype wire

//--- capsense_autoscan_compare_tb.sv
// Self-checking bench with an AHB-Lite master and a model of the scan.
// Assumes csac_top, csac_electrode and the bound checker compile first.
`timescale 1ns/1ns
`default_nettype none
`include "csac_map.vh"
module capsense_autoscan_compare_tb;
  localparam N = 38;
  logic hclk, hresetn, hsel, hwrite, debug_halt, suspend, dprev;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] v;
  logic [31:0] haddr, hwdata, q;
  logic [N-1:0] pin_analog, port_latch, touched;
  wire hreadyout, hresp, discharge, irq, wake_req, sense_pulse;
  wire [31:0] hrdata;
  wire [5:0] chan;
  wire [2:0] ia;
  wire [N-1:0] g_out, g_oe_n;
  int bad_count, n_tests, lf, wakes, i, ss, se;
  int cnt [64];
  csac_top #(.NCH(N), .SENSE_DIV(1)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_analog(pin_analog), .port_latch(port_latch),
    .debug_halt(debug_halt), .suspend(suspend), .sense_pulse(sense_pulse),
    .channel_select(chan), .discharge(discharge), .charge_current(ia),
    .pin_ground_out(g_out), .pin_ground_oe_n(g_oe_n), .irq(irq),
    .wake_req(wake_req));
  csac_electrode #(.NCH(N)) pad_u (.hclk(hclk), .discharge(discharge),
    .channel_select(chan), .touched(touched), .sense_pulse(sense_pulse));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Conversions are counted per channel from rising discharge edges.
  always @(posedge hclk) begin
    if (discharge === 1'b1 && dprev !== 1'b1)
      cnt[chan]++;
    if (wake_req === 1'b1)
      wakes++;
    dprev = discharge;
  end
  function automatic int lfsr(int s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // Scan model: next analog pin above the current one, reload after end.
  function automatic logic [5:0] nxt(logic [5:0] c);
    if (c == 6'(se))
      return 6'(ss);
    for (int k = c + 1; k < se; k++)
      if (pin_analog[k])
        return 6'(k);
    return 6'(se);
  endfunction
  task automatic test_done;
    $display("errors %0d in %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic fail(string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp_val(logic [63:0] g, logic [63:0] e);
    n_tests++;
    if (g !== e)
      fail($sformatf("value %h expected %h", g, e));
  endtask
  task automatic cmp_flag(logic g, logic e);
    n_tests++;
    if (g !== e)
      fail($sformatf("flag %b expected %b", g, e));
  endtask
  task automatic hang(int k);
    if (k >= 2000) begin
      fail("wait ran out");
      test_done;
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic rdy;
    int k;
    for (k = 0; k < 2000; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    hang(k);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    cmp_val(q, e);
  endtask
  task automatic until_dis(logic b);
    int k;
    for (k = 0; k < 2000 && discharge !== b; k++)
      @(posedge hclk);
    hang(k);
  endtask
  task automatic gchk;
    logic [N-1:0] gx;
    until_dis(1'b1);
    until_dis(1'b0);
    tick(3);
    gx = ~(pin_analog & ~port_latch);
    gx[chan] = 1'b1;
    cmp_val(g_oe_n, gx);
  endtask
  task automatic step(int n);
    int k;
    logic [5:0] o;
    o = chan;
    for (k = 0; k < 2000 && chan === o; k++)
      @(posedge hclk);
    hang(k);
    cmp_val(chan, nxt(o));
    cmp_val(cnt[o], n);
    cnt[o] = 0;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    debug_halt = 1'b0;
    suspend = 1'b0;
    touched = '0;
    pin_analog = 38'h00000000A8;
    port_latch = 38'h0000000080;
    dprev = 1'b0;
    cnt = '{default: 0};
    bad_count = 0;
    n_tests = 0;
    wakes = 0;
    lf = 76763;
    ss = 2;
    se = 5;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CSAC_OFS_TIMING, 32'h00000040);
    cmp_val(ia, 3'h0);
    rd(`CSAC_OFS_CONFIG, 32'h00000000);
    rd(8'h30, 32'h00000000);
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      v = {2'(i % 3), 3'(lf), 3'(i)};
      wr(`CSAC_OFS_TIMING, v);
      rd(`CSAC_OFS_TIMING, v);
      cmp_val(ia, v[2:0]);
    end
    wr(`CSAC_OFS_TIMING, 32'h00000040);
    wr(`CSAC_OFS_SCAN_START, 32'h00000003);
    rd(`CSAC_OFS_CHAN_SEL, 32'h00000000);
    wr(`CSAC_OFS_CONFIG, 32'h00000070);
    wr(`CSAC_OFS_SCAN_START, ss);
    rd(`CSAC_OFS_CHAN_SEL, ss);
    wr(`CSAC_OFS_SCAN_END, se);
    wr(`CSAC_OFS_THRESH_LOW, 32'h00000001);
    wr(`CSAC_OFS_IRQ_MASK, 32'h00000001);
    wr(`CSAC_OFS_CONTROL, 32'h00000002);
    gchk;
    step(1);
    gchk;
    step(1);
    step(1);
    debug_halt <= 1'b1;
    repeat (3) step(1);
    tick(400);
    rd(`CSAC_OFS_CONTROL, 32'h00000000);
    cmp_val(cnt[ss], 0);
    debug_halt <= 1'b0;
    wr(`CSAC_OFS_CONFIG, 32'h00000071);
    wr(`CSAC_OFS_CONTROL, 32'h00000002);
    repeat (3) step(2);
    touched <= 38'h0000000020;
    suspend <= 1'b1;
    step(2);
    for (i = 0; i < 2000 && irq !== 1'b1; i++)
      tick(1);
    tick(300);
    cmp_flag(irq, 1'b1);
    cmp_val(chan, 6'h05);
    cmp_val(cnt[5], 2);
    cmp_val(wakes, 1);
    rd(`CSAC_OFS_CONTROL, 32'h00000001);
    bus(1'b0, `CSAC_OFS_RESULT, 32'h00000000);
    cmp_flag(q > 32'h00000001, 1'b1);
    wr(`CSAC_OFS_IRQ_STATUS, 32'h00000007);
    tick(1);
    cmp_flag(irq, 1'b0);
    wr(`CSAC_OFS_IRQ_MASK, 32'h00000000);
    cnt[5] = 0;
    wr(`CSAC_OFS_CONTROL, 32'h00000002);
    for (i = 0; i < 2000 && wakes < 2; i++)
      tick(1);
    tick(300);
    cmp_val(wakes, 2);
    cmp_flag(irq, 1'b0);
    cmp_val(cnt[5], 2);
    test_done;
  end
endmodule // capsense_autoscan_compare_tb
`default_nettype wire
